//--- src/rhs_port.sv
// SPI register port, bit-serial bypass and shared interrupt pin of the radio modem
`timescale 1ns/1ns
module rhs_port #(
  parameter int OSC_CYC  = rhs_pkg::OSC_START_CYC,
  parameter int HALF_CYC = rhs_pkg::BYP_HALF_CYC
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst,
  input  wire logic                       i_sck,
  input  wire logic                       i_ss_n,
  input  wire logic                       i_mosi,
  output logic                            o_miso,
  output logic                            o_miso_oe_n,
  input  wire logic                       i_power_down_n,
  output logic                            o_osc_enable,
  input  wire logic                       i_tx_mode,
  input  wire logic                       i_rx_mode,
  input  wire logic                       i_chips64,
  input  wire logic                       i_double_rate,
  input  wire logic [rhs_pkg::TX_EV_W-1:0] i_tx_events,
  input  wire logic [rhs_pkg::RX_EV_W-1:0] i_rx_events,
  output logic                            o_irq,
  output logic                            o_irq_oe_n,
  input  wire logic                       i_bit_serial,
  input  wire logic                       i_bypass_serial_bit,
  output logic                            o_bypass_serial_bit,
  output logic                            o_bypass_serial_bit_oe_n,
  input  wire logic                       i_bypass_bit_qualifier,
  output logic                            o_bypass_bit_qualifier,
  output logic                            o_bypass_bit_qualifier_oe_n,
  input  wire logic                       i_rx_bit,
  input  wire logic                       i_rx_bit_qual,
  output logic                            o_rx_bit_take,
  output logic                            o_tx_bit,
  output logic                            o_tx_bit_qual,
  output logic                            o_tx_bit_stb
);
  import rhs_pkg::*;

  logic [SYNC_W-1:0]  sync1;
  logic [SYNC_W-1:0]  sync2;
  logic               sck_d;
  rhs_spi_e           spi_st;
  rhs_spi_e           next_spi_st;
  logic [2:0]         bit_cnt;
  logic [2:0]         next_bit_cnt;
  logic [7:0]         sh_in;
  logic [7:0]         next_sh_in;
  logic [7:0]         sh_out;
  logic [7:0]         next_sh_out;
  logic               dir;
  logic               next_dir;
  logic               inc;
  logic               next_inc;
  logic [ADDR_W-1:0]  addr;
  logic [ADDR_W-1:0]  next_addr;
  logic [1:0]         cfg;
  logic [1:0]         next_cfg;
  logic [RX_EV_W-1:0] rx_en;
  logic [RX_EV_W-1:0] next_rx_en;
  logic [RX_EV_W-1:0] rx_st;
  logic [RX_EV_W-1:0] next_rx_st;
  logic [TX_EV_W-1:0] tx_en;
  logic [TX_EV_W-1:0] next_tx_en;
  logic [TX_EV_W-1:0] tx_st;
  logic [TX_EV_W-1:0] next_tx_st;
  logic               wk_en;
  logic               next_wk_en;
  logic               wk_st;
  logic               next_wk_st;
  logic               next_miso;
  logic               next_miso_oe_n;
  logic               sck_rise;
  logic               sck_fall;
  logic               ss_act;
  logic [7:0]         byte_in;
  logic               done;
  logic               fetch;
  logic [ADDR_W-1:0]  fetch_addr;
  logic               wr;
  logic [RX_EV_W-1:0] rx_ev;
  logic               irq_req;
  logic               next_irq;
  logic               next_irq_oe_n;
  logic [CNT_W-1:0]   osc_cnt;
  logic [CNT_W-1:0]   next_osc_cnt;
  logic               osc_run;
  logic               next_osc_run;
  logic               wake_set;
  logic [CNT_W-1:0]   div_cnt;
  logic [CNT_W-1:0]   next_div_cnt;
  logic               bclk;
  logic               next_bclk;
  logic               bfall;
  logic               next_bbit;
  logic               next_bqual;
  logic               next_boe_n;
  logic               next_take;
  logic               next_tbit;
  logic               next_tqual;
  logic               next_tstb;

  function automatic logic [7:0] reg_rd(input logic [ADDR_W-1:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      A_IRQ_CFG: v = {6'h00, cfg};
      A_RX_EN:   v = rx_en;
      A_RX_ST:   v = rx_st;
      A_TX_EN:   v = {4'h0, tx_en};
      A_TX_ST:   v = {4'h0, tx_st};
      A_WK_EN:   v = {7'h00, wk_en};
      A_WK_ST:   v = {7'h00, wk_st};
      default:   v = 8'h00;
    endcase
    return v;
  endfunction

  // Pins cross two flops; edge detection reads only the second stage
  always_ff @(posedge i_clk)
  begin
    sync1 <= {i_bypass_bit_qualifier, i_bypass_serial_bit, i_power_down_n, i_mosi, i_ss_n, i_sck};
    sync2 <= sync1;
    sck_d <= sync2[S_SCK];
  end

  // SPI engine and register file
  always_comb
  begin
    sck_rise   = sync2[S_SCK] & ~sck_d;
    sck_fall   = ~sync2[S_SCK] & sck_d;
    ss_act     = ~sync2[S_SS] & osc_run;
    byte_in    = {sh_in[6:0], sync2[S_MOSI]};
    done       = ss_act & sck_rise & (bit_cnt == LAST_BIT);
    fetch      = done & ((spi_st == RHS_CMD) ? ~byte_in[CMD_DIR] : ~dir);
    fetch_addr = (spi_st == RHS_CMD) ? byte_in[ADDR_W-1:0] :
                 (inc ? addr + 6'h01 : addr);
    wr         = done & (spi_st == RHS_DATA) & dir;
    next_spi_st  = spi_st;
    next_bit_cnt = bit_cnt;
    next_sh_in   = sh_in;
    next_sh_out  = sh_out;
    next_dir     = dir;
    next_inc     = inc;
    next_addr    = addr;
    next_cfg     = cfg;
    next_rx_en   = rx_en;
    next_tx_en   = tx_en;
    next_wk_en   = wk_en;
    next_miso    = o_miso;
    next_miso_oe_n = ~ss_act;
    if (!ss_act)
    begin
      next_spi_st  = RHS_CMD;
      next_bit_cnt = 3'h0;
      next_sh_out  = 8'h00;
      next_miso    = 1'b0;
    end
    else
    begin
      if (sck_rise)
      begin
        next_sh_in   = byte_in;
        next_bit_cnt = bit_cnt + 3'h1;
      end
      if (sck_fall)
      begin
        next_miso   = sh_out[7];
        next_sh_out = {sh_out[6:0], 1'b0};
      end
      if (done && spi_st == RHS_CMD)
      begin
        next_spi_st = RHS_DATA;
        next_dir    = byte_in[CMD_DIR];
        next_inc    = byte_in[CMD_INC];
        next_addr   = byte_in[ADDR_W-1:0];
      end
      else if (done)
        next_addr = fetch_addr;
      if (fetch)
        next_sh_out = reg_rd(fetch_addr);
    end
    // Enables only change by SPI writes, never by mode switches
    if (wr)
    begin
      case (addr)
        A_IRQ_CFG: next_cfg   = byte_in[1:0];
        A_RX_EN:   next_rx_en = byte_in;
        A_TX_EN:   next_tx_en = byte_in[TX_EV_W-1:0];
        A_WK_EN:   next_wk_en = byte_in[0];
        default:   next_cfg   = cfg;
      endcase
    end
    // Serializer B sources are cut off in the wide-code and double-rate modes
    rx_ev = i_rx_events;
    if (i_chips64 || i_double_rate)
      rx_ev[RX_EV_W-1:RX_B_LO] = '0;
    // Set wins over the read clear in the same cycle
    next_rx_st = (rx_st & ~{RX_EV_W{fetch && fetch_addr == A_RX_ST}}) | rx_ev;
    next_tx_st = (tx_st & ~{TX_EV_W{fetch && fetch_addr == A_TX_ST}}) | i_tx_events;
    next_wk_st = (wk_st & ~(fetch && fetch_addr == A_WK_ST)) | wake_set;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      spi_st <= RHS_CMD;
      bit_cnt <= 3'h0;
      sh_in <= 8'h00;
      sh_out <= 8'h00;
      dir <= 1'b0;
      inc <= 1'b0;
      addr <= '0;
      cfg <= CFG_RST;
      rx_en <= '0;
      rx_st <= '0;
      tx_en <= '0;
      tx_st <= '0;
      wk_en <= 1'b0;
      wk_st <= WAKE_RST;
      o_miso <= 1'b0;
      o_miso_oe_n <= 1'b1;
    end
    else
    begin
      spi_st <= next_spi_st;
      bit_cnt <= next_bit_cnt;
      sh_in <= next_sh_in;
      sh_out <= next_sh_out;
      dir <= next_dir;
      inc <= next_inc;
      addr <= next_addr;
      cfg <= next_cfg;
      rx_en <= next_rx_en;
      rx_st <= next_rx_st;
      tx_en <= next_tx_en;
      tx_st <= next_tx_st;
      wk_en <= next_wk_en;
      wk_st <= next_wk_st;
      o_miso <= next_miso;
      o_miso_oe_n <= next_miso_oe_n;
    end
  end

  // Oscillator start timer after power-down release
  always_comb
  begin
    next_osc_cnt = osc_cnt;
    next_osc_run = osc_run;
    wake_set     = 1'b0;
    if (!sync2[S_PD])
    begin
      next_osc_cnt = '0;
      next_osc_run = 1'b0;
    end
    else if (!osc_run)
    begin
      next_osc_cnt = osc_cnt + 16'h0001;
      if (osc_cnt == CNT_W'(OSC_CYC - 1))
      begin
        next_osc_run = 1'b1;
        wake_set     = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      osc_cnt <= '0;
      osc_run <= 1'b0;
      o_osc_enable <= 1'b0;
    end
    else
    begin
      osc_cnt <= next_osc_cnt;
      osc_run <= next_osc_run;
      o_osc_enable <= sync2[S_PD];
    end
  end

  // Bypass bit clock and data; it borrows the interrupt pin
  always_comb
  begin
    bfall        = bclk & (div_cnt == CNT_W'(HALF_CYC - 1));
    next_div_cnt = (div_cnt == CNT_W'(HALF_CYC - 1)) ? '0 : div_cnt + 16'h0001;
    next_bclk    = (div_cnt == CNT_W'(HALF_CYC - 1)) ? ~bclk : bclk;
    if (!i_bit_serial)
    begin
      next_div_cnt = '0;
      next_bclk    = 1'b0;
    end
    next_bbit  = o_bypass_serial_bit;
    next_bqual = o_bypass_bit_qualifier;
    next_boe_n = ~(i_bit_serial & ~i_tx_mode);
    next_take  = 1'b0;
    next_tbit  = o_tx_bit;
    next_tqual = o_tx_bit_qual;
    next_tstb  = 1'b0;
    if (i_bit_serial && bfall && !i_tx_mode)
    begin
      next_bbit  = i_rx_bit;
      next_bqual = i_rx_bit_qual;
      next_take  = 1'b1;
    end
    if (i_bit_serial && bfall && i_tx_mode)
    begin
      next_tbit  = sync2[S_BIT];
      next_tqual = sync2[S_QUAL];
      next_tstb  = 1'b1;
    end
  end

  // Interrupt aggregation and pin drive
  always_comb
  begin
    irq_req = ((|(rx_st & rx_en)) & ~i_tx_mode) |
              ((|(tx_st & tx_en)) & ~i_rx_mode) | (wk_st & wk_en);
    if (i_bit_serial)
    begin
      next_irq      = next_bclk;
      next_irq_oe_n = 1'b0;
    end
    else
    begin
      case (cfg)
        PIN_OSRC:
        begin
          next_irq      = 1'b1;
          next_irq_oe_n = ~irq_req;
        end
        PIN_ODRN:
        begin
          next_irq      = 1'b0;
          next_irq_oe_n = ~irq_req;
        end
        PIN_CMOS:
        begin
          next_irq      = irq_req;
          next_irq_oe_n = 1'b0;
        end
        default:
        begin
          next_irq      = ~irq_req;
          next_irq_oe_n = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      div_cnt <= '0;
      bclk <= 1'b0;
      o_bypass_serial_bit <= 1'b0;
      o_bypass_bit_qualifier <= 1'b0;
      o_bypass_serial_bit_oe_n <= 1'b1;
      o_bypass_bit_qualifier_oe_n <= 1'b1;
      o_rx_bit_take <= 1'b0;
      o_tx_bit <= 1'b0;
      o_tx_bit_qual <= 1'b0;
      o_tx_bit_stb <= 1'b0;
      o_irq <= 1'b1;
      o_irq_oe_n <= 1'b1;
    end
    else
    begin
      div_cnt <= next_div_cnt;
      bclk <= next_bclk;
      o_bypass_serial_bit <= next_bbit;
      o_bypass_bit_qualifier <= next_bqual;
      o_bypass_serial_bit_oe_n <= next_boe_n;
      o_bypass_bit_qualifier_oe_n <= next_boe_n;
      o_rx_bit_take <= next_take;
      o_tx_bit <= next_tbit;
      o_tx_bit_qual <= next_tqual;
      o_tx_bit_stb <= next_tstb;
      o_irq <= next_irq;
      o_irq_oe_n <= next_irq_oe_n;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_cmd_done;
    done && spi_st == RHS_CMD;
  endsequence
  sequence s_data_inc;
    done && spi_st == RHS_DATA && inc;
  endsequence
  sequence s_rx_fall;
    i_bit_serial && bfall && !i_tx_mode;
  endsequence
  chk_cmd_latch: assert property (s_cmd_done |=> spi_st == RHS_DATA && dir == $past(byte_in[7]))
    else $error("command byte not latched");
  chk_addr_inc: assert property (s_data_inc |=> addr == $past(addr) + 6'h01)
    else $error("burst address did not advance");
  chk_ss_end: assert property (sync2[S_SS] |=> spi_st == RHS_CMD && bit_cnt == 3'h0 && o_miso_oe_n)
    else $error("select release did not end the burst");
  chk_bypass_rx: assert property (s_rx_fall |=> o_bypass_serial_bit == $past(i_rx_bit) && o_rx_bit_take)
    else $error("bypass receive bit not presented");
  chk_rx_mask: assert property (i_tx_mode && !i_rx_mode && (tx_st & tx_en) == '0 && !(wk_st && wk_en) |-> !irq_req)
    else $error("receive interrupt leaked in transmit mode");
  chk_b_silent: assert property ((i_chips64 || i_double_rate) && rx_st[7:4] == 4'h0 |=> rx_st[7:4] == 4'h0)
    else $error("serializer B status fired");
  chk_poll_status: assert property (i_rx_events[0] && rx_en[0] == 1'b0 |=> rx_st[0])
    else $error("status missed with enable off");
  chk_wake_clear: assert property (fetch && fetch_addr == A_WK_ST && !wake_set |=> !wk_st)
    else $error("wake status not cleared by read");
  chk_wake_set: assert property (wake_set |=> wk_st && osc_run)
    else $error("wake status not set after start");
  chk_pin_odrain: assert property (!i_bit_serial && cfg == PIN_ODRN |=> !o_irq || o_irq_oe_n)
    else $error("open-drain pin driven high");
endmodule

//--- src/rhs_pkg.sv
// Constants shared by the radio host port
package rhs_pkg;
  localparam int          ADDR_W       = 6;
  localparam int          DATA_W       = 8;
  localparam int          TX_EV_W      = 4;
  localparam int          RX_EV_W      = 8;
  localparam int          RX_B_LO      = 4;
  localparam int          CMD_DIR      = 7;
  localparam int          CMD_INC      = 6;
  localparam logic [2:0]  LAST_BIT     = 3'h7;
  localparam logic [5:0]  A_IRQ_CFG    = 6'h05;
  localparam logic [5:0]  A_RX_EN      = 6'h07;
  localparam logic [5:0]  A_RX_ST      = 6'h08;
  localparam logic [5:0]  A_TX_EN      = 6'h0d;
  localparam logic [5:0]  A_TX_ST      = 6'h0e;
  localparam logic [5:0]  A_WK_EN      = 6'h1c;
  localparam logic [5:0]  A_WK_ST      = 6'h1d;
  localparam logic [1:0]  CFG_RST      = 2'h1;
  localparam logic [1:0]  PIN_OSRC     = 2'h3;
  localparam logic [1:0]  PIN_ODRN     = 2'h2;
  localparam logic [1:0]  PIN_CMOS     = 2'h1;
  localparam logic        WAKE_RST     = 1'b1;
  localparam int          S_SCK        = 0;
  localparam int          S_SS         = 1;
  localparam int          S_MOSI       = 2;
  localparam int          S_PD         = 3;
  localparam int          S_BIT        = 4;
  localparam int          S_QUAL       = 5;
  localparam int          SYNC_W       = 6;
  localparam int          CLK_MHZ      = 25;
  localparam int          OSC_START_US = 100;
  localparam int          OSC_START_CYC = OSC_START_US * CLK_MHZ;
  localparam int          BYP_HALF_NS  = 4000;
  localparam int          BYP_HALF_CYC = BYP_HALF_NS * CLK_MHZ / 1000;
  localparam int          CNT_W        = 16;
  typedef enum logic {RHS_CMD, RHS_DATA} rhs_spi_e;
endpackage

//--- dv/rhs_spi_master.sv
// SPI master model standing in for the application controller
`timescale 1ns/1ns
module rhs_spi_master (
  input  wire logic i_clk,
  input  wire logic i_miso,
  output logic      o_sck,
  output logic      o_ss_n,
  output logic      o_mosi
);
  initial
  begin
    o_sck  = 1'b0;
    o_ss_n = 1'b1;
    o_mosi = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #2;
  endtask
  // Select edges get settle time so the port sees command framing reset
  task automatic sel(input logic v);
    tick(2);
    o_ss_n = v;
    if (v)
      o_mosi = ~o_mosi;
    tick(4);
  endtask
  // Short high and long low phase: MISO lags the falling edge by several clocks
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      o_mosi = tx[i];
      tick(6);
      rx[i] = i_miso;
      o_sck = 1'b1;
      tick(2);
      o_sck = 1'b0;
    end
  endtask
endmodule

//--- dv/tb_top.sv
// Self-checking bench of the radio host port
`timescale 1ns/1ns
module tb_top;
  import rhs_pkg::*;
  localparam int OSC = 20;
  typedef struct packed {logic [5:0] a; logic [7:0] d; logic [7:0] e;} rhs_row_s;
  logic clk, rst, pd_n, txm, rxm, c64, ddr, bser, mbit, mq, rxb, rxq;
  logic tgl = 1'b0;
  logic sck, ss_n, mosi, miso, miso_oe_n, osc, irq, irq_oe_n, bo, bo_oe, qo, qo_oe;
  logic take, tbit, tq, stb;
  logic [3:0] txe;
  logic [7:0] rxe, rd;
  int n_fail, checks_done;
  wire miso_w = miso_oe_n ? tgl : miso;
  wire bpin = bo_oe ? mbit : bo;
  wire qpin = qo_oe ? mq : qo;
  rhs_row_s rows [7] = '{'{A_IRQ_CFG, 8'hff, 8'h03}, '{A_RX_EN, 8'ha5, 8'ha5},
    '{A_TX_EN, 8'h5a, 8'h0a}, '{A_WK_EN, 8'hff, 8'h01}, '{6'h3f, 8'h77, 8'h00},
    '{A_TX_ST, 8'hff, 8'h00}, '{A_RX_ST, 8'hff, 8'h00}};
  rhs_spi_master m_u (.i_clk(clk), .i_miso(miso_w), .o_sck(sck), .o_ss_n(ss_n), .o_mosi(mosi));
  rhs_port #(.OSC_CYC(OSC), .HALF_CYC(4)) dut_u (
    .i_clk(clk), .i_rst(rst), .i_sck(sck), .i_ss_n(ss_n), .i_mosi(mosi), .o_miso(miso),
    .o_miso_oe_n(miso_oe_n), .i_power_down_n(pd_n), .o_osc_enable(osc), .i_tx_mode(txm),
    .i_rx_mode(rxm), .i_chips64(c64), .i_double_rate(ddr), .i_tx_events(txe),
    .i_rx_events(rxe), .o_irq(irq), .o_irq_oe_n(irq_oe_n), .i_bit_serial(bser),
    .i_bypass_serial_bit(bpin), .o_bypass_serial_bit(bo), .o_bypass_serial_bit_oe_n(bo_oe),
    .i_bypass_bit_qualifier(qpin), .o_bypass_bit_qualifier(qo),
    .o_bypass_bit_qualifier_oe_n(qo_oe), .i_rx_bit(rxb), .i_rx_bit_qual(rxq),
    .o_rx_bit_take(take), .o_tx_bit(tbit), .o_tx_bit_qual(tq), .o_tx_bit_stb(stb));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Released MISO shows a toggling level so a stale bit never matches
  always @(posedge clk) tgl <= ~tgl;
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic stop_test;
    $display("Checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic lvl(input int w, input logic v);
    int k;
    for (k = 0; k < 60; k++)
    begin
      if (((w == 0) ? irq : (w == 1) ? stb : osc) === v)
        break;
      cyc(1);
    end
    if (k == 60)
    begin
      n_fail++;
      $display("Error t=%0t wait timed out", $time);
      stop_test();
    end
  endtask
  task automatic boot;
    lvl(2, 1'b1);
    cyc(OSC + 8);
  endtask
  task automatic bur(input logic [7:0] c, input logic [7:0] d0, d1, e0, e1);
    m_u.sel(1'b0);
    m_u.xfer(c, rd);
    m_u.xfer(d0, rd);
    if (!c[CMD_DIR])
      chk(rd, e0);
    m_u.xfer(d1, rd);
    if (!c[CMD_DIR])
      chk(rd, e1);
    m_u.sel(1'b1);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bur({2'b10, a}, d, d, 8'h00, 8'h00);
  endtask
  task automatic rdc(input logic [5:0] a, input logic [7:0] e);
    m_u.sel(1'b0);
    m_u.xfer({2'b00, a}, rd);
    m_u.xfer(8'h00, rd);
    m_u.sel(1'b1);
    chk(rd, e);
  endtask
  task automatic pulse(input logic [3:0] t, input logic [7:0] r);
    txe = t;
    rxe = r;
    cyc(1);
    txe = 4'h0;
    rxe = 8'h00;
    cyc(3);
  endtask
  initial
  begin
    {txm, rxm, c64, ddr, bser, mbit, mq, rxb, rxq} = '0;
    txe = 4'h0;
    rxe = 8'h00;
    rd = 8'h00;
    n_fail = 0;
    checks_done = 0;
    pd_n = 1'b1;
    rst = 1'b1;
    cyc(12);
    rst = 1'b0;
    boot();
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rdc(rows[i].a, rows[i].e);
    end
    rst = 1'b1;
    cyc(12);
    rst = 1'b0;
    boot();
    rdc(A_IRQ_CFG, 8'h01);
    rdc(A_RX_EN, 8'h00);
    rdc(A_TX_EN, 8'h00);
    chk(8'({irq, irq_oe_n}), 8'h00);
    rdc(A_WK_ST, 8'h01);
    rdc(A_WK_ST, 8'h00);
    wr(A_WK_EN, 8'h01);
    pd_n = 1'b0;
    cyc(6);
    chk(8'(osc), 8'h00);
    pd_n = 1'b1;
    boot();
    chk(8'({irq, irq_oe_n}), 8'h02);
    rdc(A_WK_ST, 8'h01);
    chk(8'({irq, irq_oe_n}), 8'h00);
    wr(A_WK_EN, 8'h00);
    txm = 1'b1;
    wr(A_TX_EN, 8'h01);
    pulse(4'h2, 8'h00);
    chk(8'({irq, irq_oe_n}), 8'h00);
    for (int c = 3; c >= 0; c--)
    begin
      pulse(4'h1, 8'h00);
      wr(A_IRQ_CFG, 8'(c));
      chk(8'({irq, irq_oe_n}), {6'h0, c[0], 1'b0});
      rdc(A_TX_ST, (c == 3) ? 8'h03 : 8'h01);
      cyc(3);
      chk(8'(irq_oe_n), 8'(c[1]));
      if (!c[1])
        chk(8'(irq), 8'(!c[0]));
    end
    wr(A_IRQ_CFG, 8'h01);
    pulse(4'h1, 8'h00);
    pulse(4'h0, 8'h01);
    rdc(A_RX_ST, 8'h01);
    wr(A_RX_EN, 8'hff);
    txm = 1'b0;
    rxm = 1'b1;
    cyc(3);
    chk(8'({irq, irq_oe_n}), 8'h00);
    for (int m = 1; m < 3; m++)
    begin
      {c64, ddr} = 2'(m);
      pulse(4'h0, 8'hf0);
      rdc(A_RX_ST, 8'h00);
    end
    {c64, ddr} = 2'h0;
    pulse(4'h0, 8'h10);
    chk(8'({irq, irq_oe_n}), 8'h02);
    rdc(A_RX_ST, 8'h10);
    chk(8'({irq, irq_oe_n}), 8'h00);
    rdc(A_TX_EN, 8'h01);
    rdc(A_TX_ST, 8'h01);
    bur(8'h8d, 8'h11, 8'h22, 8'h00, 8'h00);
    rdc(A_TX_EN, 8'h02);
    bur(8'hcd, 8'h01, 8'h5a, 8'h00, 8'h00);
    rdc(A_TX_EN, 8'h01);
    bur(8'h47, 8'h00, 8'h00, 8'hff, 8'h00);
    bur(8'h05, 8'h00, 8'h00, 8'h01, 8'h01);
    bser = 1'b1;
    for (int k = 0; k < 6; k++)
    begin
      lvl(0, 1'b0);
      if (k > 0)
        chk(8'(take), 8'h01);
      lvl(0, 1'b1);
      if (k > 0)
        chk(8'({bpin, qpin, bo_oe}), {5'h0, rxb, rxq, 1'b0});
      rxb = k[0];
      rxq = k[1];
    end
    rxm = 1'b0;
    txm = 1'b1;
    for (int k = 0; k < 6; k++)
    begin
      lvl(0, 1'b0);
      lvl(0, 1'b1);
      mbit = k[0];
      mq = !k[1];
      lvl(1, 1'b1);
      chk(8'({tbit, tq, bo_oe}), {5'h0, mbit, mq, 1'b1});
    end
    stop_test();
  end
endmodule
